// [amc_config_regs.sv]
// Playback and miscellaneous configuration register bank with shutdown and retry control.
`timescale 1ns/1ps

// Operation
// (RQ1) Playback bit 6 set disables DC removal.
// (RQ2) DC removal applies to PCM data only.
// (RQ3) Five-bit level code, bits 5:1, reset 10h.
// (RQ4) Over-current retry after 1.5 s when set.
// (RQ5) Over-temperature retry after 1.5 s when set.
// (RQ6) Battery POR retry bit 6, default on.
// (RQ7) Pump-good retry bit 7, default on.
// (RQ8) Bit 3 enables interrupt pin pull-up.
// (RQ9) Bit 2 enables spread spectrum, default on.
// (RQ10) Two-bit field selects shutdown pin behaviour.
// (RQ11) Two-bit field selects forced shutdown timeout.
// (RQ12) Timer forces shutdown unless graceful completed.
// (RQ13) Bit 2 bypasses battery reading filter.
// (RQ14) Bit 0 bypasses power rail filter.
// (RQ15) Bit 1 enables broadcast address, default on.
// (RQ16) Soft restore returns registers to defaults.
module amc_config_regs
    import amc_pkg::*;
#(
    parameter int RETRY_CYC     = amc_pkg::AMC_RETRY_CYC,
    parameter int TIMEOUT_0_CYC = amc_pkg::AMC_TIMEOUT_0_CYC,
    parameter int TIMEOUT_1_CYC = amc_pkg::AMC_TIMEOUT_1_CYC,
    parameter int TIMEOUT_2_CYC = amc_pkg::AMC_TIMEOUT_2_CYC,
    parameter int TIMEOUT_3_CYC = amc_pkg::AMC_TIMEOUT_3_CYC
) (
    // Clock and reset.
    input  wire logic                   CLK_I,
    input  wire logic                   RESETN_I,
    // Register access from the control bus logic.
    input  wire amc_pkg::amc_wreq_type  WREQ_I,
    input  wire logic                   SOFT_RESTORE_I,
    input  wire logic [7:0]             RD_ADDR_I,
    output logic [7:0]                  RD_DATA_O,
    // Playback path.
    input  wire logic                   PCM_FORMAT_I,
    output logic                        DC_REMOVAL_ACTIVE_O,
    output logic [4:0]                  AMP_LEVEL_O,
    // Faults and retry.
    input  wire amc_pkg::amc_fault_type FAULT_I,
    output logic [3:0]                  RETRY_O,
    // Pin and analog controls.
    output logic                        IRQ_PIN_PULLUP_EN_O,
    output logic                        SPREAD_SPECTRUM_EN_O,
    output logic                        BATTERY_FILTER_BYPASS_O,
    output logic                        POWER_RAIL_FILTER_BYPASS_O,
    output logic                        BROADCAST_ADDRESS_EN_O,
    // Shutdown pin handling.
    input  wire logic                   SHUTDOWN_PIN_N_I,
    input  wire logic                   GRACEFUL_DONE_I,
    output logic                        GRACEFUL_REQ_O,
    output logic                        FORCE_SHUTDOWN_O
);
    import amc_pkg::*;

    typedef enum logic [1:0] {
        AMC_ST_RUN   = 2'b00,
        AMC_ST_GRACE = 2'b01,
        AMC_ST_FORCE = 2'b10,
        AMC_ST_DOWN  = 2'b11
    } amc_sd_state_type;

    logic [7:0]       pb_q, misc_a_q, misc_b_q;
    logic             sdn_meta_q, sdn_sync_q, pcm_meta_q, pcm_sync_q;
    logic             gdone_meta_q, gdone_sync_q;
    logic [31:0]      sd_count_q;
    amc_sd_state_type sd_state_q, sd_state_d;
    logic [3:0]       retry_w;
    logic [7:0]       rd_data_d;

    // Register writes and soft restore; a restore outranks a write in the same cycle.
    wire wr_pb_w     = WREQ_I.wr && (WREQ_I.addr == AMC_OFS_PLAYBACK_CONFIG);
    wire wr_misc_a_w = WREQ_I.wr && (WREQ_I.addr == AMC_OFS_MISC_CONFIG_A);
    wire wr_misc_b_w = WREQ_I.wr && (WREQ_I.addr == AMC_OFS_MISC_CONFIG_B);

    // Writes land here; restore reloads every default.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pb_q     <= AMC_RST_PLAYBACK_CONFIG;
            misc_a_q <= AMC_RST_MISC_CONFIG_A;
            misc_b_q <= AMC_RST_MISC_CONFIG_B;
        end
        else if (SOFT_RESTORE_I) // RQ16
        begin
            pb_q     <= AMC_RST_PLAYBACK_CONFIG;
            misc_a_q <= AMC_RST_MISC_CONFIG_A;
            misc_b_q <= AMC_RST_MISC_CONFIG_B;
        end
        else
        begin
            if (wr_pb_w)
                pb_q <= WREQ_I.data & AMC_WMASK_PLAYBACK;
            if (wr_misc_a_w)
                misc_a_q <= WREQ_I.data;
            if (wr_misc_b_w)
                misc_b_q <= WREQ_I.data;
        end
    end

    // Pins from outside are synchronised before any logic reads them.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sdn_meta_q   <= 1'b1;
            sdn_sync_q   <= 1'b1;
            pcm_meta_q   <= 1'b0;
            pcm_sync_q   <= 1'b0;
            gdone_meta_q <= 1'b0;
            gdone_sync_q <= 1'b0;
        end
        else
        begin
            sdn_meta_q   <= SHUTDOWN_PIN_N_I;
            sdn_sync_q   <= sdn_meta_q;
            pcm_meta_q   <= PCM_FORMAT_I;
            pcm_sync_q   <= pcm_meta_q;
            gdone_meta_q <= GRACEFUL_DONE_I;
            gdone_sync_q <= gdone_meta_q;
        end
    end

    // Field decode for the shutdown controller.
    wire [1:0] sd_mode_w  = misc_b_q[AMC_POS_SHUTDOWN_BEHAVIOUR +: 2];
    wire [1:0] sd_delay_w = misc_b_q[AMC_POS_SHUTDOWN_DELAY +: 2];
    wire       sd_req_w   = !sdn_sync_q;
    wire [31:0] sd_limit_w = (sd_delay_w == 2'b00) ? 32'(TIMEOUT_0_CYC) : // RQ11
                             (sd_delay_w == 2'b01) ? 32'(TIMEOUT_1_CYC) :
                             (sd_delay_w == 2'b10) ? 32'(TIMEOUT_2_CYC) :
                                                     32'(TIMEOUT_3_CYC);

    // Next state of the shutdown controller; reserved mode behaves as graceful-only.
    always_comb
    begin
        sd_state_d = sd_state_q;
        unique case (sd_state_q)
            AMC_ST_RUN:
                if (sd_req_w)
                    sd_state_d = (sd_mode_w == AMC_SD_FORCE_NOW) ? AMC_ST_FORCE // RQ10
                                                                 : AMC_ST_GRACE;
            AMC_ST_GRACE:
                if (!sd_req_w)
                    sd_state_d = AMC_ST_RUN;
                else if (gdone_sync_q)
                    sd_state_d = AMC_ST_DOWN; // RQ12
                else if (sd_mode_w == AMC_SD_GRACE_THEN_FORCE && sd_count_q >= sd_limit_w)
                    sd_state_d = AMC_ST_FORCE; // RQ12
            AMC_ST_FORCE,
            AMC_ST_DOWN:
                if (!sd_req_w)
                    sd_state_d = AMC_ST_RUN;
        endcase
    end

    // State and timeout counter; the count starts at the request.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sd_state_q <= AMC_ST_RUN;
            sd_count_q <= 32'h0000_0000;
        end
        else
        begin
            sd_state_q <= sd_state_d;
            sd_count_q <= (sd_state_d == AMC_ST_GRACE) ? sd_count_q + 32'h0000_0001
                                                       : 32'h0000_0000;
        end
    end

    // One retry timer per fault class, each gated by its own enable bit.
    wire [3:0] retry_en_w = {misc_a_q[AMC_BIT_PUMP_GOOD_RETRY],   // RQ7
                             misc_a_q[AMC_BIT_BATTERY_POR_RETRY], // RQ6
                             misc_a_q[AMC_BIT_OVERCURRENT_RETRY], // RQ4
                             misc_a_q[AMC_BIT_OVERTEMP_RETRY]};   // RQ5
    wire [3:0] fault_w    = FAULT_I;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_retry
            amc_retry_timer #(
                .DELAY_CYC (RETRY_CYC)
            ) u_timer (
                .CLK_I        (CLK_I),
                .RESETN_I     (RESETN_I),
                .soft_clear_i (SOFT_RESTORE_I),
                .enable_i     (retry_en_w[gi]),
                .fault_i      (fault_w[gi]),
                .retry_o      (retry_w[gi])
            );
        end
    endgenerate

    // Read decode; unmapped offsets read as zero.
    always_comb
    begin
        unique case (RD_ADDR_I)
            AMC_OFS_PLAYBACK_CONFIG: rd_data_d = pb_q;
            AMC_OFS_MISC_CONFIG_A:   rd_data_d = misc_a_q;
            AMC_OFS_MISC_CONFIG_B:   rd_data_d = misc_b_q;
            default:                 rd_data_d = 8'h00;
        endcase
    end

    // All outputs leave from flip-flops, so controls lag the register by one cycle.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            RD_DATA_O                  <= 8'h00;
            DC_REMOVAL_ACTIVE_O        <= 1'b0;
            AMP_LEVEL_O                <= AMC_RST_PLAYBACK_CONFIG[AMC_POS_AMP_LEVEL_LO +: 5];
            RETRY_O                    <= 4'h0;
            IRQ_PIN_PULLUP_EN_O        <= AMC_RST_MISC_CONFIG_A[AMC_BIT_IRQ_PIN_PULLUP_EN];
            SPREAD_SPECTRUM_EN_O       <= AMC_RST_MISC_CONFIG_A[AMC_BIT_SPREAD_SPECTRUM_EN];
            BATTERY_FILTER_BYPASS_O    <= AMC_RST_MISC_CONFIG_B[AMC_BIT_BATTERY_FLT_BYPASS];
            POWER_RAIL_FILTER_BYPASS_O <= AMC_RST_MISC_CONFIG_B[AMC_BIT_RAIL_FLT_BYPASS];
            BROADCAST_ADDRESS_EN_O     <= AMC_RST_MISC_CONFIG_B[AMC_BIT_BROADCAST_ADDR_EN];
            GRACEFUL_REQ_O             <= 1'b0;
            FORCE_SHUTDOWN_O           <= 1'b0;
        end
        else
        begin
            RD_DATA_O                  <= rd_data_d;
            DC_REMOVAL_ACTIVE_O        <= !pb_q[AMC_BIT_DC_REMOVAL_DISABLE]
                                          && pcm_sync_q; // RQ1 RQ2
            AMP_LEVEL_O                <= pb_q[AMC_POS_AMP_LEVEL_LO +: 5]; // RQ3
            RETRY_O                    <= retry_w;
            IRQ_PIN_PULLUP_EN_O        <= misc_a_q[AMC_BIT_IRQ_PIN_PULLUP_EN]; // RQ8
            SPREAD_SPECTRUM_EN_O       <= misc_a_q[AMC_BIT_SPREAD_SPECTRUM_EN]; // RQ9
            BATTERY_FILTER_BYPASS_O    <= misc_b_q[AMC_BIT_BATTERY_FLT_BYPASS]; // RQ13
            POWER_RAIL_FILTER_BYPASS_O <= misc_b_q[AMC_BIT_RAIL_FLT_BYPASS]; // RQ14
            BROADCAST_ADDRESS_EN_O     <= misc_b_q[AMC_BIT_BROADCAST_ADDR_EN]; // RQ15
            GRACEFUL_REQ_O             <= (sd_state_d == AMC_ST_GRACE);
            FORCE_SHUTDOWN_O           <= (sd_state_d == AMC_ST_FORCE);
        end
    end

    // Forced shutdown in mode 01 follows the synchronised request on the next cycle.
    a_force_now: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ10
        (sd_state_q == AMC_ST_RUN && sd_req_w && sd_mode_w == AMC_SD_FORCE_NOW)
            |=> FORCE_SHUTDOWN_O)
        else $error("immediate force shutdown missing");

    // Graceful-only mode never forces.
    a_grace_only: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ10
        (sd_state_q == AMC_ST_GRACE && sd_mode_w == AMC_SD_GRACE_ONLY) |=> !FORCE_SHUTDOWN_O)
        else $error("graceful-only mode forced shutdown");

    // Timeout elapse forces unless graceful completed.
    a_timeout_force: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ12
        (sd_state_q == AMC_ST_GRACE && sd_req_w && !gdone_sync_q
         && sd_mode_w == AMC_SD_GRACE_THEN_FORCE && sd_count_q >= sd_limit_w)
            |=> FORCE_SHUTDOWN_O)
        else $error("timeout did not force shutdown");

    // Soft restore reloads defaults.
    sequence s_restore;
        SOFT_RESTORE_I;
    endsequence
    a_restore_vals: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ16
        s_restore |=> (pb_q == AMC_RST_PLAYBACK_CONFIG && misc_a_q == AMC_RST_MISC_CONFIG_A
                       && misc_b_q == AMC_RST_MISC_CONFIG_B))
        else $error("soft restore left non-default value");

    // Level output tracks written code.
    a_level_track: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ3
        (wr_pb_w && !SOFT_RESTORE_I) |=> ##1 (AMP_LEVEL_O == $past(WREQ_I.data[5:1], 2)))
        else $error("level code not applied");

    // DC removal never active for non-PCM data.
    a_dc_pcm_only: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ1 RQ2
        DC_REMOVAL_ACTIVE_O |-> $past(pcm_sync_q) && !$past(pb_q[AMC_BIT_DC_REMOVAL_DISABLE]))
        else $error("dc removal active outside pcm");

    // Disabled retry never fires.
    a_retry_gate: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ4 RQ5 RQ6 RQ7
        (retry_en_w == 4'h0) [*2] |-> ##1 (RETRY_O == 4'h0))
        else $error("retry without enable");

    // Broadcast and filter controls follow their bits.
    a_misc_b_map: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ13 RQ14 RQ15
        ##1 ({BATTERY_FILTER_BYPASS_O, BROADCAST_ADDRESS_EN_O, POWER_RAIL_FILTER_BYPASS_O}
             == $past(misc_b_q[2:0])))
        else $error("misc b controls mismatch");

    // Pull-up and spread spectrum follow their bits.
    a_misc_a_map: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ8 RQ9
        ##1 ({IRQ_PIN_PULLUP_EN_O, SPREAD_SPECTRUM_EN_O} == $past(misc_a_q[3:2])))
        else $error("misc a controls mismatch");

endmodule // amc_config_regs

// [amc_config_regs_tb_top.sv]
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps

`define AMC_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module amc_config_regs_tb_top;
    import amc_pkg::*;

    // Short counts keep the run brief; every expectation uses these.
    localparam int RTY = 50;

    // One table row: write, expected readback, expected control outputs.
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rexp;
        logic [10:0] oexp;
    } amc_tb_row_type;

    logic          CLK_I = 1'b0;
    logic          RESETN_I = 1'b0;
    amc_wreq_type  WREQ_I = '0;
    logic          SOFT_RESTORE_I = 1'b0;
    logic [7:0]    RD_ADDR_I = 8'h00;
    logic [7:0]    RD_DATA_O;
    logic          PCM_FORMAT_I = 1'b1;
    logic          DC_REMOVAL_ACTIVE_O;
    logic [4:0]    AMP_LEVEL_O;
    amc_fault_type FAULT_I = '0;
    logic [3:0]    RETRY_O;
    logic          IRQ_PIN_PULLUP_EN_O;
    logic          SPREAD_SPECTRUM_EN_O;
    logic          BATTERY_FILTER_BYPASS_O;
    logic          POWER_RAIL_FILTER_BYPASS_O;
    logic          BROADCAST_ADDRESS_EN_O;
    logic          SHUTDOWN_PIN_N_I = 1'b1;
    logic          GRACEFUL_DONE_I = 1'b0;
    logic          GRACEFUL_REQ_O;
    logic          FORCE_SHUTDOWN_O;
    int            error_cnt = 0;
    int            num_checks = 0;
    logic [7:0]    v;
    logic [3:0]    seen;
    int            n;
    int            n2;
    wire  [10:0]   obs = {DC_REMOVAL_ACTIVE_O, AMP_LEVEL_O, IRQ_PIN_PULLUP_EN_O,
                          SPREAD_SPECTRUM_EN_O, BATTERY_FILTER_BYPASS_O,
                          BROADCAST_ADDRESS_EN_O, POWER_RAIL_FILTER_BYPASS_O};

    // Rows are cumulative: each starts from the state the previous one left.
    amc_tb_row_type rows [9] = '{
        '{8'h03, 8'hFF, 8'h7F, {1'h0, 5'h1F, 5'h0A}},
        '{8'h03, 8'h02, 8'h02, {1'h1, 5'h01, 5'h0A}},
        '{8'h03, 8'h3A, 8'h3A, {1'h1, 5'h1D, 5'h0A}},
        '{8'h04, 8'h08, 8'h08, {1'h1, 5'h1D, 5'h12}},
        '{8'h04, 8'hC4, 8'hC4, {1'h1, 5'h1D, 5'h0A}},
        '{8'h05, 8'h05, 8'h05, {1'h1, 5'h1D, 5'h0D}},
        '{8'h05, 8'h02, 8'h02, {1'h1, 5'h1D, 5'h0A}},
        '{8'h06, 8'hFF, 8'h00, {1'h1, 5'h1D, 5'h0A}},
        '{8'h02, 8'hFF, 8'h00, {1'h1, 5'h1D, 5'h0A}}};
    logic [7:0] rst_val [3] = '{8'h20, 8'hC6, 8'h22};

    // Free-running 20 MHz clock.
    always #25 CLK_I = ~CLK_I;

    amc_config_regs #(
        .RETRY_CYC     (RTY),
        .TIMEOUT_0_CYC (10),
        .TIMEOUT_1_CYC (20),
        .TIMEOUT_2_CYC (30),
        .TIMEOUT_3_CYC (40)
    ) dut (
        .CLK_I                      (CLK_I),
        .RESETN_I                   (RESETN_I),
        .WREQ_I                     (WREQ_I),
        .SOFT_RESTORE_I             (SOFT_RESTORE_I),
        .RD_ADDR_I                  (RD_ADDR_I),
        .RD_DATA_O                  (RD_DATA_O),
        .PCM_FORMAT_I               (PCM_FORMAT_I),
        .DC_REMOVAL_ACTIVE_O        (DC_REMOVAL_ACTIVE_O),
        .AMP_LEVEL_O                (AMP_LEVEL_O),
        .FAULT_I                    (FAULT_I),
        .RETRY_O                    (RETRY_O),
        .IRQ_PIN_PULLUP_EN_O        (IRQ_PIN_PULLUP_EN_O),
        .SPREAD_SPECTRUM_EN_O       (SPREAD_SPECTRUM_EN_O),
        .BATTERY_FILTER_BYPASS_O    (BATTERY_FILTER_BYPASS_O),
        .POWER_RAIL_FILTER_BYPASS_O (POWER_RAIL_FILTER_BYPASS_O),
        .BROADCAST_ADDRESS_EN_O     (BROADCAST_ADDRESS_EN_O),
        .SHUTDOWN_PIN_N_I           (SHUTDOWN_PIN_N_I),
        .GRACEFUL_DONE_I            (GRACEFUL_DONE_I),
        .GRACEFUL_REQ_O             (GRACEFUL_REQ_O),
        .FORCE_SHUTDOWN_O           (FORCE_SHUTDOWN_O)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One write cycle; the strobe drops on the next edge so writes never merge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        WREQ_I <= '{wr: 1'b1, addr: a, data: d};
        @(posedge CLK_I);
        WREQ_I.wr <= 1'b0;
    endtask

    // Read data is registered, so it is sampled one edge after the address.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK_I);
        RD_ADDR_I <= a;
        @(posedge CLK_I);
        #1 d = RD_DATA_O;
    endtask

    // Selects a watched output: retry bits 0..3, then force, then grace.
    function automatic logic sig(input int k);
        return (k < 4) ? RETRY_O[k] : (k == 4) ? FORCE_SHUTDOWN_O : GRACEFUL_REQ_O;
    endfunction

    // Bounded wait for a watched output; n is the number of edges it took.
    task automatic wait_for(input int k, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && sig(k) !== 1'b1)
        begin
            @(posedge CLK_I);
            #1 cnt++;
        end
    endtask

    // Asserts reset for 8 cycles and checks the register and output defaults.
    task automatic do_reset();
        RESETN_I <= 1'b0;
        repeat (8) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rd(8'h03 + 8'(i), v);
            `AMC_CHK(v, rst_val[i])
        end
        `AMC_CHK(obs, {1'h1, 5'h10, 5'h0A})
    endtask

    // Releases the shutdown pin and expects the block back in run.
    task automatic pin_release();
        @(posedge CLK_I);
        SHUTDOWN_PIN_N_I <= 1'b1;
        GRACEFUL_DONE_I  <= 1'b0;
        repeat (6) @(posedge CLK_I);
        #1 `AMC_CHK({GRACEFUL_REQ_O, FORCE_SHUTDOWN_O}, 2'h0)
    endtask

    // Watchdog sized well above the roughly eight hundred cycles of the run.
    initial
    begin
        #(30000 * 50);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    initial
    begin
        do_reset();
        // Table of ordinary writes, each followed by readback and outputs.
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, v);
            `AMC_CHK(v, rows[i].rexp)
            `AMC_CHK(obs, rows[i].oexp)
        end
        // DC removal follows the PCM indication, not only the register bit.
        @(posedge CLK_I);
        PCM_FORMAT_I <= 1'b0;
        repeat (6) @(posedge CLK_I);
        #1 `AMC_CHK(DC_REMOVAL_ACTIVE_O, 1'b0)
        @(posedge CLK_I);
        PCM_FORMAT_I <= 1'b1;
        repeat (6) @(posedge CLK_I);
        #1 `AMC_CHK(DC_REMOVAL_ACTIVE_O, 1'b1)
        // Soft restore in the same cycle as a write; the restore must win.
        wr(8'h04, 8'h00);
        wr(8'h05, 8'hF7);
        @(posedge CLK_I);
        SOFT_RESTORE_I <= 1'b1;
        WREQ_I <= '{wr: 1'b1, addr: 8'h03, data: 8'h7F};
        @(posedge CLK_I);
        SOFT_RESTORE_I <= 1'b0;
        WREQ_I.wr <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(8'h03 + 8'(i), v);
            `AMC_CHK(v, rst_val[i])
        end
        // Each fault class retries once after the delay, as a one-cycle pulse.
        wr(8'h04, 8'hF4);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge CLK_I);
            FAULT_I <= amc_fault_type'(4'h1 << k);
            @(posedge CLK_I);
            FAULT_I <= '0;
            wait_for(k, RTY + 10, n);
            `AMC_CHK(n >= RTY - 3 && n <= RTY + 3, 1'b1)
            `AMC_CHK(RETRY_O, 4'h1 << k)
            @(posedge CLK_I);
            #1 `AMC_CHK(RETRY_O, 4'h0)
        end
        // With every retry bit clear no fault may ever be retried.
        wr(8'h04, 8'h04);
        @(posedge CLK_I);
        FAULT_I <= '1;
        @(posedge CLK_I);
        FAULT_I <= '0;
        seen = 4'h0;
        repeat (2 * RTY)
        begin
            @(posedge CLK_I);
            #1 seen = seen | RETRY_O;
        end
        `AMC_CHK(seen, 4'h0)
        // Graceful then forced: force arrives after each selectable timeout.
        for (int t = 0; t < 4; t++)
        begin
            wr(8'h05, {2'h0, 2'(t), 4'h2});
            @(posedge CLK_I);
            SHUTDOWN_PIN_N_I <= 1'b0;
            wait_for(5, 8, n);
            `AMC_CHK(GRACEFUL_REQ_O, 1'b1)
            wait_for(4, 60, n2);
            `AMC_CHK(n2 >= 10 * (t + 1) - 1 && n2 <= 10 * (t + 1) + 2, 1'b1)
            pin_release();
        end
        // Graceful completion before the timeout cancels the forced shutdown.
        wr(8'h05, 8'h02);
        @(posedge CLK_I);
        SHUTDOWN_PIN_N_I <= 1'b0;
        repeat (4) @(posedge CLK_I);
        GRACEFUL_DONE_I <= 1'b1;
        seen = 4'h0;
        repeat (30)
        begin
            @(posedge CLK_I);
            #1 seen[0] = seen[0] | FORCE_SHUTDOWN_O;
        end
        `AMC_CHK({seen[0], GRACEFUL_REQ_O}, 2'h0)
        pin_release();
        // Immediate forced shutdown.
        wr(8'h05, 8'h62);
        @(posedge CLK_I);
        SHUTDOWN_PIN_N_I <= 1'b0;
        wait_for(4, 6, n);
        `AMC_CHK(n <= 5 && FORCE_SHUTDOWN_O === 1'b1, 1'b1)
        pin_release();
        // Graceful only, and the reserved code, never force.
        for (int m = 2; m < 4; m++)
        begin
            wr(8'h05, {2'(m), 6'h22});
            @(posedge CLK_I);
            SHUTDOWN_PIN_N_I <= 1'b0;
            seen = 4'h0;
            repeat (60)
            begin
                @(posedge CLK_I);
                #1 seen[0] = seen[0] | FORCE_SHUTDOWN_O;
            end
            `AMC_CHK({seen[0], GRACEFUL_REQ_O}, 2'h1)
            pin_release();
        end
        // A second hardware reset in mid-run restores the defaults again.
        wr(8'h03, 8'h7F);
        do_reset();
        conclude();
    end

endmodule // amc_config_regs_tb_top

// [amc_pkg.sv]
// Package with register map, field layout, reset values and timing of the config bank.
package amc_pkg;

    // Register offsets on the control bus.
    localparam logic [7:0] AMC_OFS_PLAYBACK_CONFIG = 8'h03;
    localparam logic [7:0] AMC_OFS_MISC_CONFIG_A   = 8'h04;
    localparam logic [7:0] AMC_OFS_MISC_CONFIG_B   = 8'h05;

    // Values after reset.
    localparam logic [7:0] AMC_RST_PLAYBACK_CONFIG = 8'h20;
    localparam logic [7:0] AMC_RST_MISC_CONFIG_A   = 8'hC6;
    localparam logic [7:0] AMC_RST_MISC_CONFIG_B   = 8'h22;

    // Field positions.
    localparam int AMC_BIT_DC_REMOVAL_DISABLE  = 6;
    localparam int AMC_POS_AMP_LEVEL_LO        = 1;
    localparam int AMC_BIT_PUMP_GOOD_RETRY     = 7;
    localparam int AMC_BIT_BATTERY_POR_RETRY   = 6;
    localparam int AMC_BIT_OVERCURRENT_RETRY   = 5;
    localparam int AMC_BIT_OVERTEMP_RETRY      = 4;
    localparam int AMC_BIT_IRQ_PIN_PULLUP_EN   = 3;
    localparam int AMC_BIT_SPREAD_SPECTRUM_EN  = 2;
    localparam int AMC_POS_SHUTDOWN_BEHAVIOUR  = 6;
    localparam int AMC_POS_SHUTDOWN_DELAY      = 4;
    localparam int AMC_BIT_BATTERY_FLT_BYPASS  = 2;
    localparam int AMC_BIT_BROADCAST_ADDR_EN   = 1;
    localparam int AMC_BIT_RAIL_FLT_BYPASS     = 0;

    // Writable bit masks; bit 7 of the playback register is read-only zero.
    localparam logic [7:0] AMC_WMASK_PLAYBACK = 8'h7F;

    // Level code limits.
    localparam logic [4:0] AMC_LEVEL_FIRST_RESERVED = 5'h1D;

    // Clock and timing figures.
    localparam int AMC_CLK_HZ        = 20_000_000;
    localparam int AMC_RETRY_MS      = 1500;
    localparam int AMC_TIMEOUT_0_US  = 2000;
    localparam int AMC_TIMEOUT_1_US  = 4000;
    localparam int AMC_TIMEOUT_2_US  = 6000;
    localparam int AMC_TIMEOUT_3_US  = 23800;
    localparam int AMC_RETRY_CYC     = (AMC_CLK_HZ / 1000) * AMC_RETRY_MS;
    localparam int AMC_TIMEOUT_0_CYC = (AMC_CLK_HZ / 1_000_000) * AMC_TIMEOUT_0_US;
    localparam int AMC_TIMEOUT_1_CYC = (AMC_CLK_HZ / 1_000_000) * AMC_TIMEOUT_1_US;
    localparam int AMC_TIMEOUT_2_CYC = (AMC_CLK_HZ / 1_000_000) * AMC_TIMEOUT_2_US;
    localparam int AMC_TIMEOUT_3_CYC = (AMC_CLK_HZ / 1_000_000) * AMC_TIMEOUT_3_US;

    // Shutdown pin behaviour codes.
    typedef enum logic [1:0] {
        AMC_SD_GRACE_THEN_FORCE = 2'b00,
        AMC_SD_FORCE_NOW        = 2'b01,
        AMC_SD_GRACE_ONLY       = 2'b10,
        AMC_SD_RESERVED         = 2'b11
    } amc_sd_mode_type;

    // Register write request.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } amc_wreq_type;

    // Fault events that can trigger a retry.
    typedef struct packed {
        logic pump_good;
        logic battery_por;
        logic overcurrent;
        logic overtemp;
    } amc_fault_type;

endpackage

// [amc_retry_timer.sv]
// Retry timer for one shutdown fault class.
`timescale 1ns/1ps

module amc_retry_timer #(
    parameter int DELAY_CYC = amc_pkg::AMC_RETRY_CYC
) (
    // Clock and reset.
    input  wire logic CLK_I,
    input  wire logic RESETN_I,
    input  wire logic soft_clear_i,
    // Control.
    input  wire logic enable_i,
    input  wire logic fault_i,
    // Result.
    output logic      retry_o
);
    logic [31:0] count_q;
    logic        busy_q;
    logic        retry_q;
    wire         done_w = busy_q && (count_q == 32'h0000_0001);

    // A fault with retry off leaves the block down; disabling mid-wait abandons the retry.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            count_q <= 32'h0000_0000;
            busy_q  <= 1'b0;
            retry_q <= 1'b0;
        end
        else if (soft_clear_i || !enable_i)
        begin
            count_q <= 32'h0000_0000;
            busy_q  <= 1'b0;
            retry_q <= 1'b0;
        end
        else if (fault_i && !busy_q)
        begin
            count_q <= 32'(DELAY_CYC);
            busy_q  <= 1'b1;
            retry_q <= 1'b0;
        end
        else
        begin
            count_q <= busy_q ? count_q - 32'h0000_0001 : count_q;
            busy_q  <= busy_q && !done_w;
            retry_q <= done_w;
        end
    end

    assign retry_o = retry_q;

endmodule // amc_retry_timer
